// >>> rtl/arf_defs.svh
`ifndef ARF_DEFS_SVH
`define ARF_DEFS_SVH

// ****************************************************************
// Timing of the pin sequences, in ns and in 100 MHz cycles.
// ****************************************************************
`define ARF_CLK_NS      10
`define ARF_CLR_NS      100
`define ARF_STB_HIGH_NS 50
`define ARF_SETTLE_NS   50
`define ARF_CLR_CYC  ((`ARF_CLR_NS + `ARF_CLK_NS - 1) / `ARF_CLK_NS)
`define ARF_HIGH_CYC ((`ARF_STB_HIGH_NS + `ARF_CLK_NS - 1) / `ARF_CLK_NS)
`define ARF_SETTLE_CYC ((`ARF_SETTLE_NS + `ARF_CLK_NS - 1) / `ARF_CLK_NS)

// ****************************************************************
// Word layout.
// ****************************************************************
`define ARF_WORD_W   4
`define ARF_DEPTH    16
`define ARF_CNT_W    4

`endif

// >>> rtl/arf_pkg.sv
package arf_pkg;

   // Load side sequence on the pins.
   typedef enum logic [1:0] {
      LD_IDLE,
      LD_SETUP,
      LD_HIGH,
      LD_SETTLE
   } arf_load_type;

   // Unload side sequence on the pins.
   typedef enum logic [1:0] {
      UL_IDLE,
      UL_HIGH,
      UL_SETTLE
   } arf_unload_type;

endpackage

// >>> rtl/arf_buffer.sv
`timescale 1ns/10ps

// ****************************************************************
// Small buffer between the unload sequence and the consumer.
// ****************************************************************
module arf_buffer #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 2
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             resetn,
   // Filling side.
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side.
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wrPtr_reg;
   logic [PW-1:0]    rdPtr_reg;
   logic [PW:0]      count_reg;
   logic             push;
   logic             pop;

   // Full and empty follow the occupancy count directly.
   assign inReady  = (count_reg != (PW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outData  = mem_reg[rdPtr_reg];

   // Pointers wrap at the depth, which need not be a power of two.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   // Storage needs no reset; nothing reads an entry before it is written.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wrPtr_reg] <= inData;
      end
   end

endmodule

// >>> rtl/arf_host.sv
`timescale 1ns/10ps
`include "arf_defs.svh"

// What this block does
// - Pulse clear once after each reset.
// - Raise load strobe only when space flagged.
// - Return load strobe low after each rise.
// - Hold load strobe high until the space flag drops.
// - Return unload strobe low before next word.
module arf_host #(
   parameter int WORD_W  = `ARF_WORD_W,
   parameter int BUF_DEP = 2
) (
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              resetn,
   // Producer side of this controller.
   input  wire logic              wrValid,
   output logic                   wrReady,
   input  wire logic [WORD_W-1:0] wrData,
   // Consumer side of this controller.
   output logic                   rdValid,
   input  wire logic              rdReady,
   output logic [WORD_W-1:0]      rdData,
   // Status of this controller.
   output logic                   clearBusy,
   // Pins toward the store.
   output logic [WORD_W-1:0]      wordIn,
   output logic                   loadStrobe,
   output logic                   unloadStrobe,
   output logic                   clearAll,
   output logic                   outEnableN,
   input  wire logic              inSpaceFlag,
   input  wire logic              outputValidFlag,
   input  wire logic [WORD_W-1:0] wordOut
);

   // ****************************************************************
   // Helpers.
   // ****************************************************************

   // A count has run out once it reaches zero.
   function automatic logic timeUp(input logic [`ARF_CNT_W-1:0] c);
      timeUp = (c == '0);
   endfunction

   localparam logic [`ARF_CNT_W-1:0] CLR_CYC    = `ARF_CNT_W'(`ARF_CLR_CYC);
   localparam logic [`ARF_CNT_W-1:0] HIGH_CYC   = `ARF_CNT_W'(`ARF_HIGH_CYC);
   localparam logic [`ARF_CNT_W-1:0] SETTLE_CYC =
      `ARF_CNT_W'(`ARF_SETTLE_CYC);

   // ****************************************************************
   // Pin synchronisers.
   // ****************************************************************

   // Two stages for every level from the store; only stage two is read.
   logic [WORD_W+1:0] syncA_reg;
   logic [WORD_W+1:0] syncB_reg;
   logic              spaceS;
   logic              validS;
   logic [WORD_W-1:0] wordS;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         syncA_reg <= '0;
         syncB_reg <= '0;
      end else begin
         syncA_reg <= {inSpaceFlag, outputValidFlag, wordOut};
         syncB_reg <= syncA_reg;
      end
   end

   assign spaceS = syncB_reg[WORD_W+1];
   assign validS = syncB_reg[WORD_W];
   assign wordS  = syncB_reg[WORD_W-1:0];

   // ****************************************************************
   // Clear pulse after reset.
   // ****************************************************************

   // The store starts in an unknown state, so it is cleared first.
   logic [`ARF_CNT_W-1:0] clrCnt_reg;
   logic                  clrDone;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clrCnt_reg <= CLR_CYC;
      end else if (!timeUp(clrCnt_reg)) begin
         clrCnt_reg <= clrCnt_reg - 1'b1;
      end
   end

   // The clear pin stays high until the count runs out.
   assign clrDone   = timeUp(clrCnt_reg);
   assign clearAll  = !clrDone;
   assign clearBusy = !clrDone;

   // Keep the store's outputs driven once it is in use; during clear
   // they are floated because the word on them means nothing.
   assign outEnableN = !clrDone;

   // ****************************************************************
   // Load sequence.
   // ****************************************************************
   arf_pkg::arf_load_type ldState_reg;
   arf_pkg::arf_load_type ldState_next;
   logic [`ARF_CNT_W-1:0] ldCnt_reg;
   logic [`ARF_CNT_W-1:0] ldCnt_next;
   logic [WORD_W-1:0]     wordIn_reg;
   logic                  ldTake;

   // A word is accepted only while the store flags space, and the
   // strobe stays low during clear so nothing is caught at release.
   assign ldTake  = (ldState_reg == arf_pkg::LD_IDLE) && clrDone
                    && spaceS && wrValid;
   assign wrReady = (ldState_reg == arf_pkg::LD_IDLE) && clrDone && spaceS;
   assign wordIn  = wordIn_reg;

   // The strobe rises one cycle after the word is set up, stays high at
   // least the minimum time and until the store shows busy, then falls.
   always_comb begin
      ldState_next = ldState_reg;
      ldCnt_next   = timeUp(ldCnt_reg) ? ldCnt_reg : ldCnt_reg - 1'b1;
      case (ldState_reg)
         arf_pkg::LD_IDLE: begin
            if (ldTake) begin
               ldState_next = arf_pkg::LD_SETUP;
            end
         end
         arf_pkg::LD_SETUP: begin
            ldState_next = arf_pkg::LD_HIGH;
            ldCnt_next   = HIGH_CYC;
         end
         arf_pkg::LD_HIGH: begin
            // Waiting on a low flag also covers a full store.
            if (timeUp(ldCnt_reg) && !spaceS) begin
               ldState_next = arf_pkg::LD_SETTLE;
               ldCnt_next   = SETTLE_CYC;
            end
         end
         arf_pkg::LD_SETTLE: begin
            // The synchronised flag lags; let it catch up first.
            if (timeUp(ldCnt_reg)) begin
               ldState_next = arf_pkg::LD_IDLE;
            end
         end
         default: begin
            ldState_next = arf_pkg::LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ldState_reg <= arf_pkg::LD_IDLE;
         ldCnt_reg   <= '0;
         wordIn_reg  <= '0;
      end else begin
         ldState_reg <= ldState_next;
         ldCnt_reg   <= ldCnt_next;
         if (ldTake) begin
            wordIn_reg <= wrData;
         end
      end
   end

   // Data is held steady across the whole strobe pulse.
   assign loadStrobe = (ldState_reg == arf_pkg::LD_HIGH);

   // ****************************************************************
   // Unload sequence.
   // ****************************************************************
   arf_pkg::arf_unload_type ulState_reg;
   arf_pkg::arf_unload_type ulState_next;
   logic [`ARF_CNT_W-1:0]   ulCnt_reg;
   logic [`ARF_CNT_W-1:0]   ulCnt_next;
   logic                    ulTake;
   logic                    bufInReady;

   // A word is taken only with room in the buffer, so a stalled
   // consumer leaves words waiting in the store instead of losing them.
   assign ulTake = (ulState_reg == arf_pkg::UL_IDLE) && clrDone
                   && validS && bufInReady;

   // The strobe is raised, and its falling edge releases the word; it
   // rests low between words so it is never held over an empty store.
   always_comb begin
      ulState_next = ulState_reg;
      ulCnt_next   = timeUp(ulCnt_reg) ? ulCnt_reg : ulCnt_reg - 1'b1;
      case (ulState_reg)
         arf_pkg::UL_IDLE: begin
            if (ulTake) begin
               ulState_next = arf_pkg::UL_HIGH;
               ulCnt_next   = HIGH_CYC;
            end
         end
         arf_pkg::UL_HIGH: begin
            if (timeUp(ulCnt_reg)) begin
               ulState_next = arf_pkg::UL_SETTLE;
               ulCnt_next   = SETTLE_CYC;
            end
         end
         arf_pkg::UL_SETTLE: begin
            // Stale valid from before the fall must clear the sampler.
            if (timeUp(ulCnt_reg)) begin
               ulState_next = arf_pkg::UL_IDLE;
            end
         end
         default: begin
            ulState_next = arf_pkg::UL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ulState_reg <= arf_pkg::UL_IDLE;
         ulCnt_reg   <= '0;
      end else begin
         ulState_reg <= ulState_next;
         ulCnt_reg   <= ulCnt_next;
      end
   end

   assign unloadStrobe = (ulState_reg == arf_pkg::UL_HIGH);

   // ****************************************************************
   // Buffer toward the consumer.
   // ****************************************************************
   arf_buffer #(
      .WIDTH (WORD_W),
      .DEPTH (BUF_DEP)
   ) uBuffer (
      .clk      (clk),
      .resetn   (resetn),
      .inValid  (ulTake),
      .inReady  (bufInReady),
      .inData   (wordS),
      .outValid (rdValid),
      .outReady (rdReady),
      .outData  (rdData)
   );

endmodule

// >>> testbench/arf_store_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Behavioural sixteen-word store on the far side of the host.
// ****************************************************************
module arf_store_model (
   // Control pins.
   input  wire logic       clearAll,
   input  wire logic       loadStrobe,
   input  wire logic       unloadStrobe,
   input  wire logic       outEnableN,
   // Data and flags.
   input  wire logic [3:0] wordIn,
   output logic            inSpaceFlag,
   output logic            outputValidFlag,
   output logic [3:0]      wordOut
);
   int         lag = 30;
   logic [3:0] q[$];     // Filled positions, output end first.
   logic [3:0] held;
   logic [3:0] stage;
   logic       cap = 1'b0;
   logic       hold = 1'b0;  // Unload strobe held over an empty store.
   logic       ldPrev = 1'b0;
   logic       ulPrev = 1'b0;
   int         tIn = 0;
   int         tOut = 0;
   // A released bus shows the inverse, so stale data cannot match.
   assign wordOut = outEnableN ? ~stage : stage;
   // Each 1 ns step samples the strobes and moves words.
   // Lag sets how slow the ripple is, so flag delays can be stretched.
   always begin
      #1;
      if (clearAll) begin
         q.delete();
         cap = 1'b0;
         hold = 1'b0;
         tIn = 0;
         outputValidFlag = 1'b0;
      end else begin
         // Taken on the rise, or later once room appears.
         if (loadStrobe && !cap && q.size() < 16) begin
            held = wordIn;
            cap = 1'b1;
         end
         if (!loadStrobe && ldPrev && cap) begin
            tOut = (q.size() == 0) ? lag : tOut;
            q.push_back(held);
            cap = 1'b0;
            tIn = lag;
         end
         if (!unloadStrobe && ulPrev && outputValidFlag) begin
            void'(q.pop_front());
            outputValidFlag = 1'b0;
            tOut = lag;
            tIn = lag;
         end
         // A strobe held high over an empty store unloads the next
         // arriving word by itself, so the valid flag only pulses.
         if (!unloadStrobe) begin
            hold = 1'b0;
         end else if (q.size() == 0 && !outputValidFlag) begin
            hold = 1'b1;
         end else if (hold && outputValidFlag) begin
            void'(q.pop_front());
            outputValidFlag = 1'b0;
            hold = 1'b0;
            tOut = lag;
            tIn = lag;
         end
         if (tOut > 0) begin
            tOut--;
         end else if (q.size() > 0 && !outputValidFlag) begin
            stage = q[0];
            outputValidFlag = 1'b1;
         end
         if (tIn > 0) begin
            tIn--;
         end
      end
      inSpaceFlag = !cap && tIn == 0 && q.size() < 16;
      ldPrev = loadStrobe;
      ulPrev = unloadStrobe;
   end
endmodule

// >>> testbench/arf_host_props.sv
`timescale 1ns/10ps

// ****************************************************************
// Pin sequence checks on the host controller.
// ****************************************************************
module arf_host_props #(
   parameter int WORD_W = 4
) (
   // Clock and reset.
   input wire logic              clk,
   input wire logic              resetn,
   // User side.
   input wire logic              wrValid,
   input wire logic              wrReady,
   input wire logic [WORD_W-1:0] wrData,
   input wire logic              rdValid,
   input wire logic              rdReady,
   input wire logic [WORD_W-1:0] rdData,
   input wire logic              clearBusy,
   // Store pins.
   input wire logic [WORD_W-1:0] wordIn,
   input wire logic              loadStrobe,
   input wire logic              unloadStrobe,
   input wire logic              clearAll,
   input wire logic              outEnableN,
   input wire logic              inSpaceFlag,
   input wire logic              outputValidFlag,
   input wire logic [WORD_W-1:0] wordOut
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // An unload is a held strobe whose fall moves the store.
   sequence unload_s;
      unloadStrobe [*6] ##1 !unloadStrobe;
   endsequence
   sequence take_s;
      wrValid && wrReady;
   endsequence
   reset_pins_a:
      assert property (disable iff (1'b0) !resetn |-> clearAll && outEnableN
         && !loadStrobe && !unloadStrobe && !rdValid)
      else $error("store pins wrong during reset");
   clear_len_a:
      assert property ($fell(clearAll) |-> $past(clearAll, 8))
      else $error("clear pulse too short");
   oe_follow_a:
      assert property ($fell(clearAll) |-> ##[0:1] !outEnableN)
      else $error("outputs not enabled after clear");
   quiet_clear_a:
      assert property (clearAll |-> !loadStrobe && !unloadStrobe)
      else $error("strobe during clear");
   load_launch_a:
      assert property (take_s |=> wordIn == $past(wrData) ##1 $rose(loadStrobe))
      else $error("load not launched after take");
   load_width_a:
      assert property ($rose(loadStrobe) |-> loadStrobe [*5])
      else $error("load strobe too short");
   load_release_a:
      assert property ($fell(loadStrobe) |-> !$past(inSpaceFlag, 3))
      else $error("load strobe fell before busy shown");
   word_steady_a:
      assert property (loadStrobe |-> $stable(wordIn) && !wrReady)
      else $error("load word changed under strobe");
   unload_pulse_a:
      assert property ($rose(unloadStrobe) |-> unload_s)
      else $error("unload strobe width wrong");
   unload_cause_a:
      assert property ($rose(unloadStrobe) |-> $past(outputValidFlag, 2)
         || $past(outputValidFlag, 3))
      else $error("unload without valid word");
   word_kept_a:
      assert property (rdValid && !rdReady |=> rdValid && $stable(rdData))
      else $error("read word lost while stalled");
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/10ps

// ****************************************************************
// Host controller against the store model.
// ****************************************************************
module tb_top;
   logic       clk = 1'b0;
   logic       resetn = 1'b1;
   logic       wrValid = 1'b0;
   logic       rdReady = 1'b0;
   logic [3:0] wrData = 4'h0;
   logic       wrReady, rdValid, clearBusy, loadStrobe, unloadStrobe;
   logic       clearAll, outEnableN, inSpaceFlag, outputValidFlag;
   logic [3:0] rdData, wordIn, wordOut;
   int         failures = 0;
   int         checked = 0;

   always #5 clk = ~clk;

   arf_host u_arf_host (.clk(clk), .resetn(resetn), .wrValid(wrValid),
      .wrReady(wrReady), .wrData(wrData), .rdValid(rdValid),
      .rdReady(rdReady), .rdData(rdData), .clearBusy(clearBusy),
      .wordIn(wordIn), .loadStrobe(loadStrobe), .unloadStrobe(unloadStrobe),
      .clearAll(clearAll), .outEnableN(outEnableN), .wordOut(wordOut),
      .inSpaceFlag(inSpaceFlag), .outputValidFlag(outputValidFlag));
   arf_store_model u_arf_store_model (.clearAll(clearAll),
      .loadStrobe(loadStrobe), .unloadStrobe(unloadStrobe),
      .outEnableN(outEnableN), .wordIn(wordIn), .wordOut(wordOut),
      .inSpaceFlag(inSpaceFlag), .outputValidFlag(outputValidFlag));

   task check(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task results;
      if (failures == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Offer a word and hold it until the controller takes it.
   task put(input logic [3:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wrValid <= 1'b1;
      wrData <= d;
      do begin
         @(negedge clk);
         n++;
      end while (wrReady !== 1'b1 && n < 2000);
      check("wrReady", {7'h0, wrReady}, 8'h01);
      @(posedge clk);
      wrValid <= 1'b0;
   endtask
   // Ask for one word and compare it on the falling edge before the accepting edge.
   task get(input logic [3:0] e);
      int n;
      n = 0;
      @(posedge clk);
      rdReady <= 1'b1;
      do begin
         @(negedge clk);
         n++;
      end while (rdValid !== 1'b1 && n < 2000);
      check("rdWord", {3'h0, rdValid, rdData}, {4'h1, e});
      @(posedge clk);
      rdReady <= 1'b0;
   endtask
   task t_reset;
      check("resetPins", {4'h0, clearAll, outEnableN, inSpaceFlag, outputValidFlag}, 8'h0e);
      @(posedge clk);
      resetn <= 1'b1;
      repeat (20) @(negedge clk);
      check("clearDone", {5'h0, clearAll, outEnableN, clearBusy}, 8'h00);
   endtask
   // Fill store and buffer until refused while the reader stalls.
   task t_fill;
      for (int i = 0; i < 18; i++) put(4'(i * 5 + 3));
      @(posedge clk);
      wrValid <= 1'b1;
      wrData <= 4'hc;
      repeat (60) @(negedge clk);
      check("fullFlags", {6'h0, wrReady, inSpaceFlag}, 8'h00);
      @(posedge clk);
      wrValid <= 1'b0;
      for (int i = 0; i < 18; i++) get(4'(i * 5 + 3));
      put(4'hc);
      get(4'hc);
   endtask
   // A slow store stretches every flag; order must still hold.
   task t_slow;
      u_arf_store_model.lag = 400;
      put(4'h5);
      put(4'ha);
      get(4'h5);
      get(4'ha);
      u_arf_store_model.lag = 30;
   endtask
   // Reset in mid-run discards stored words.
   task t_midreset;
      put(4'h1);
      put(4'h2);
      repeat (100) @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      check("midClear", {6'h0, inSpaceFlag, outputValidFlag}, 8'h02);
      resetn <= 1'b1;
      repeat (60) @(negedge clk);
      check("emptyAfter", {7'h0, rdValid}, 8'h00);
      put(4'h9);
      get(4'h9);
   endtask

   initial begin
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset;
      t_fill;
      t_slow;
      t_midreset;
      results;
   end
   // Cut a hang short well past the expected run time.
   initial begin
      #900000;
      failures++;
      results;
   end
endmodule

bind arf_host arf_host_props #(.WORD_W(WORD_W)) u_arf_host_props (.*);
